// [sac_cfg.svh]
`ifndef SAC_CFG_SVH
`define SAC_CFG_SVH

// Result word and bit positions
`define SAC_RES_MSB      4'h9
`define SAC_RES_ZERO     10'h000
`define SAC_RES_ONE      10'h001
`define SAC_SAR_STEPS    4'hA

// Serial frame counts
`define SAC_CHAN_LAST    4'h2
`define SAC_MSB_LAST     4'h9
`define SAC_LSB_LAST     4'h8
`define SAC_CNT_ZERO     4'h0
`define SAC_CNT_STEP     4'h1

// Result buffer shape
`define SAC_FIFO_W       10
`define SAC_FIFO_DEPTH   16

// Serial clock droop watch: half of the slowest allowed period
`define SAC_CLK_KHZ      50000
`define SAC_SCLK_MIN_KHZ 10
`define SAC_GAP_MAX_CYC  12'((`SAC_CLK_KHZ / `SAC_SCLK_MIN_KHZ) / 2)
`define SAC_GAP_ZERO     12'h000
`define SAC_GAP_STEP     12'h001

`endif

// [sac_pkg.sv]
`default_nettype none
package sac_pkg;

    // Frame sequencer states
    typedef enum logic [2:0] {
        ST_STANDBY,
        ST_IDLE,
        ST_MODE,
        ST_CHAN,
        ST_SAMPLE,
        ST_MSB,
        ST_LSB,
        ST_ZEROS
    } sac_state_t;

    // Command bits taken from the serial input
    typedef struct packed {
        logic input_mode_bit;
        logic channel_bit_2;
        logic channel_bit_1;
        logic channel_bit_0;
    } sac_cmd_t;

    // Analog multiplexer and hold switch control
    typedef struct packed {
        logic       sample;
        logic       diff;
        logic [2:0] pos;
        logic [2:0] neg;
    } sac_mux_t;

endpackage
`default_nettype wire

// [sac_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
module sac_fifo #(
    parameter int unsigned WIDTH = 10,
    parameter int unsigned DEPTH = 16
) (
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    input  wire logic             flush_in,
    // Filling side
    input  wire logic             in_valid_in,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  in_ready_out,
    // Draining side
    output logic                  out_valid_out,
    output logic      [WIDTH-1:0] out_data_out,
    input  wire logic             out_ready_in
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_q, wr_d;
    logic [AW:0]      rd_q, rd_d;
    logic             full;
    logic             empty;
    logic             push;
    logic             pop;

    // Extra pointer bit tells full from empty
    assign empty = (wr_q == rd_q);
    assign full  = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    assign in_ready_out  = ~full;
    assign out_valid_out = ~empty;
    assign out_data_out  = mem[rd_q[AW-1:0]];
    assign push = in_valid_in & ~full;
    assign pop  = out_ready_in & ~empty;

    // Pointer update; flush drops a stale result at once
    always_comb begin
        wr_d = wr_q;
        rd_d = rd_q;
        if (flush_in) begin
            wr_d = '0;
            rd_d = '0;
        end else begin
            if (push) wr_d = wr_q + 1'b1;
            if (pop)  rd_d = rd_q + 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
        end
    end

    // Storage has no reset; empty flag guards it
    always_ff @(posedge clk_in) begin
        if (push && !flush_in) mem[wr_q[AW-1:0]] <= in_data_in;
    end

    property p_full_blocks;
        @(posedge clk_in) disable iff (!rst_n_in)
        full |-> !in_ready_out && !empty;
    endproperty
    a_full_blocks: assert property (p_full_blocks)
        else $error("buffer full but still ready");

    property p_flush_empties;
        @(posedge clk_in) disable iff (!rst_n_in)
        flush_in |=> !out_valid_out && in_ready_out;
    endproperty
    a_flush_empties: assert property (p_flush_empties)
        else $error("buffer not empty after flush");

endmodule // sac_fifo
`default_nettype wire

// [sac_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
`include "sac_cfg.svh"
module sac_ctrl (
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    // Serial port
    input  wire logic             select_standby_n_in,
    input  wire logic             sclk_in,
    input  wire logic             cmd_in,
    output logic                  dout_out,
    output logic                  dout_oe_n_out,
    // Analog front end
    output sac_pkg::sac_mux_t     mux_out,
    output logic [9:0]            sar_trial_out,
    input  wire logic             comparator_in,
    // Status
    output logic                  standby_out,
    output logic                  slow_clock_out
);
    import sac_pkg::*;

    // Edge detect and session qualification
    logic       sclk_q;
    logic       sclk_rise;
    logic       sclk_fall;
    logic       armed_q, armed_d;
    logic       cs_low;

    // Frame sequencer state
    sac_state_t state_q, state_d;
    logic [3:0] cnt_q, cnt_d;
    sac_cmd_t   cmd_q, cmd_d;
    sac_mux_t   mux_q, mux_d;
    logic       seen_rise_q, seen_rise_d;
    logic       dout_q, dout_d;
    logic       oe_n_q, oe_n_d;
    logic [9:0] res_q, res_d;
    logic       have_res_q, have_res_d;
    logic       sar_start;
    logic       res_pop;

    // Approximation state
    logic       sar_busy_q, sar_busy_d;
    logic [3:0] sar_bit_q, sar_bit_d;
    logic [9:0] trial_q, trial_d;
    logic       push_q, push_d;
    logic [9:0] kept;
    logic [3:0] sar_len_q, sar_len_d;   // Trials so far, for the checker

    // Result buffer handshake
    logic       buf_in_ready;
    logic       buf_out_valid;
    logic [9:0] buf_out_data;

    // Droop watch
    logic [11:0] gap_q, gap_d;
    logic        slow_q, slow_d;

    function automatic logic [9:0] bit_mask(input logic [3:0] idx);
        bit_mask = `SAC_RES_ONE << idx;
    endfunction

    // Single inputs pass through; pairs are even/odd neighbours
    function automatic sac_mux_t mux_decode(input sac_cmd_t c,
                                            input logic     s);
        sac_mux_t   m;
        logic [2:0] ch;
        ch       = {c.channel_bit_2, c.channel_bit_1, c.channel_bit_0};
        m.sample = s;
        m.diff   = ~c.input_mode_bit;
        if (c.input_mode_bit) begin
            m.pos = ch;
            m.neg = ch;
        end else begin
            m.pos = {ch[2:1], ch[0]};
            m.neg = {ch[2:1], ~ch[0]};
        end
        return m;
    endfunction

    // Serial lines are synchronous; one flop gives the edges
    assign sclk_rise = sclk_in & ~sclk_q;
    assign sclk_fall = ~sclk_in & sclk_q;
    // A device reset with select low waits for a high first
    assign armed_d = armed_q | select_standby_n_in;
    assign cs_low  = armed_q & ~select_standby_n_in;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sclk_q  <= 1'b0;
            armed_q <= 1'b0;
        end else begin
            sclk_q  <= sclk_in;
            armed_q <= armed_d;
        end
    end

    // Frame sequencer next state
    always_comb begin
        state_d     = state_q;
        cnt_d       = cnt_q;
        cmd_d       = cmd_q;
        seen_rise_d = seen_rise_q;
        dout_d      = dout_q;
        oe_n_d      = oe_n_q;
        res_d       = res_q;
        have_res_d  = have_res_q;
        sar_start   = 1'b0;
        res_pop     = 1'b0;
        if (!cs_low) begin
            // Standby forgets the command and releases the line
            state_d     = ST_STANDBY;
            cnt_d       = `SAC_CNT_ZERO;
            cmd_d       = '0;
            seen_rise_d = 1'b0;
            dout_d      = 1'b0;
            oe_n_d      = 1'b1;
            res_d       = `SAC_RES_ZERO;
            have_res_d  = 1'b0;
        end else begin
            // Take the finished result once output has begun
            if (buf_out_valid && state_q == ST_MSB && !have_res_q) begin
                res_d      = buf_out_data;
                have_res_d = 1'b1;
                res_pop    = 1'b1;
            end
            unique case (state_q)
                ST_STANDBY: state_d = ST_IDLE;
                ST_IDLE: begin
                    // Low bits are padding until the start bit
                    if (sclk_rise && cmd_in) begin
                        state_d = ST_MODE;
                    end
                end
                ST_MODE: begin
                    if (sclk_rise) begin
                        cmd_d.input_mode_bit = cmd_in;
                        cnt_d   = `SAC_CNT_ZERO;
                        state_d = ST_CHAN;
                    end
                end
                ST_CHAN: begin
                    if (sclk_rise) begin
                        // Channel bits arrive most significant first
                        cmd_d = {cmd_q.input_mode_bit, cmd_q.channel_bit_1,
                                 cmd_q.channel_bit_0, cmd_in};
                        cnt_d = cnt_q + `SAC_CNT_STEP;
                        if (cnt_q == `SAC_CHAN_LAST) begin
                            seen_rise_d = 1'b0;
                            state_d     = ST_SAMPLE;
                        end
                    end
                end
                ST_SAMPLE: begin
                    // Hold opens on the fall after the don't-care rise
                    if (sclk_rise) begin
                        seen_rise_d = 1'b1;
                    end else if (sclk_fall && seen_rise_q) begin
                        sar_start = 1'b1;
                        dout_d    = 1'b0;
                        oe_n_d    = 1'b0;
                        cnt_d     = `SAC_CNT_ZERO;
                        state_d   = ST_MSB;
                    end
                end
                ST_MSB: begin
                    if (sclk_fall) begin
                        dout_d = res_q[`SAC_RES_MSB - cnt_q];
                        cnt_d  = cnt_q + `SAC_CNT_STEP;
                        if (cnt_q == `SAC_MSB_LAST) begin
                            cnt_d   = `SAC_CNT_ZERO;
                            state_d = ST_LSB;
                        end
                    end
                end
                ST_LSB: begin
                    // Lowest bit is shared, so resend starts at bit one
                    if (sclk_fall) begin
                        dout_d = res_q[cnt_q + `SAC_CNT_STEP];
                        cnt_d  = cnt_q + `SAC_CNT_STEP;
                        if (cnt_q == `SAC_LSB_LAST) state_d = ST_ZEROS;
                    end
                end
                ST_ZEROS: begin
                    if (sclk_fall) dout_d = 1'b0;
                end
            endcase
        end
        mux_d = mux_decode(cmd_d, state_d == ST_SAMPLE);
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q     <= ST_STANDBY;
            cnt_q       <= `SAC_CNT_ZERO;
            cmd_q       <= '0;
            mux_q       <= '0;
            seen_rise_q <= 1'b0;
            dout_q      <= 1'b0;
            oe_n_q      <= 1'b1;
            res_q       <= `SAC_RES_ZERO;
            have_res_q  <= 1'b0;
        end else begin
            state_q     <= state_d;
            cnt_q       <= cnt_d;
            cmd_q       <= cmd_d;
            mux_q       <= mux_d;
            seen_rise_q <= seen_rise_d;
            dout_q      <= dout_d;
            oe_n_q      <= oe_n_d;
            res_q       <= res_d;
            have_res_q  <= have_res_d;
        end
    end

    // Approximation: one trial per clock, MSB down
    // A comparator that never trips leaves all zeros, one that
    // always trips leaves all ones, so pairs saturate both ways
    assign kept = comparator_in ? trial_q
                                : (trial_q & ~bit_mask(sar_bit_q));
    always_comb begin
        sar_busy_d = sar_busy_q;
        sar_bit_d  = sar_bit_q;
        trial_d    = trial_q;
        push_d     = push_q;
        sar_len_d  = sar_busy_q ? sar_len_q + `SAC_CNT_STEP : `SAC_CNT_ZERO;
        if (!cs_low) begin
            sar_busy_d = 1'b0;
            sar_bit_d  = `SAC_CNT_ZERO;
            trial_d    = `SAC_RES_ZERO;
            push_d     = 1'b0;
        end else if (sar_start) begin
            sar_busy_d = 1'b1;
            sar_bit_d  = `SAC_RES_MSB;
            trial_d    = bit_mask(`SAC_RES_MSB);
            push_d     = 1'b0;
        end else if (sar_busy_q) begin
            if (sar_bit_q == `SAC_CNT_ZERO) begin
                trial_d    = kept;
                sar_busy_d = 1'b0;
                push_d     = 1'b1;
            end else begin
                sar_bit_d = sar_bit_q - `SAC_CNT_STEP;
                trial_d   = kept | bit_mask(sar_bit_q - `SAC_CNT_STEP);
            end
        end else if (push_q && buf_in_ready) begin
            push_d = 1'b0;                           // held until taken
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sar_busy_q <= 1'b0;
            sar_bit_q  <= `SAC_CNT_ZERO;
            trial_q    <= `SAC_RES_ZERO;
            push_q     <= 1'b0;
            sar_len_q  <= `SAC_CNT_ZERO;
        end else begin
            sar_busy_q <= sar_busy_d;
            sar_bit_q  <= sar_bit_d;
            trial_q    <= trial_d;
            push_q     <= push_d;
            sar_len_q  <= sar_len_d;
        end
    end

    // Result buffer between converter and shifter; flushed on abort
    sac_fifo #(
        .WIDTH (`SAC_FIFO_W),
        .DEPTH (`SAC_FIFO_DEPTH)
    ) u_buf (
        .clk_in        (clk_in),
        .rst_n_in      (rst_n_in),
        .flush_in      (~cs_low),
        .in_valid_in   (push_q),
        .in_data_in    (trial_q),
        .in_ready_out  (buf_in_ready),
        .out_valid_out (buf_out_valid),
        .out_data_out  (buf_out_data),
        .out_ready_in  (res_pop)
    );

    // Droop watch: long pause while the held sample is in use
    always_comb begin
        gap_d  = gap_q;
        slow_d = slow_q;
        if (!cs_low) begin
            gap_d  = `SAC_GAP_ZERO;
            slow_d = 1'b0;
        end else if (sclk_rise || sclk_fall ||
                     !(state_q inside {ST_SAMPLE, ST_MSB, ST_LSB})) begin
            gap_d = `SAC_GAP_ZERO;
        end else if (gap_q == `SAC_GAP_MAX_CYC) begin
            slow_d = 1'b1;
        end else begin
            gap_d = gap_q + `SAC_GAP_STEP;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            gap_q  <= `SAC_GAP_ZERO;
            slow_q <= 1'b0;
        end else begin
            gap_q  <= gap_d;
            slow_q <= slow_d;
        end
    end

    // Outputs
    assign dout_out       = dout_q;
    assign dout_oe_n_out  = oe_n_q;
    assign mux_out        = mux_q;
    assign sar_trial_out  = trial_q;
    assign standby_out    = (state_q == ST_STANDBY);
    assign slow_clock_out = slow_q;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_start;
        cs_low && state_q == ST_IDLE && sclk_rise && cmd_in;
    endsequence
    sequence s_hold_end;
        cs_low && state_q == ST_SAMPLE && seen_rise_q && sclk_fall;
    endsequence

    property p_standby_quiet;
        select_standby_n_in |=> state_q == ST_STANDBY && dout_oe_n_out
                                && !mux_out.sample && !sar_busy_q;
    endproperty
    a_standby_quiet: assert property (p_standby_quiet)
        else $error("select high did not force standby");

    property p_lead_zero;
        cs_low && state_q == ST_IDLE && sclk_rise && !cmd_in
            |=> state_q == ST_IDLE;
    endproperty
    a_lead_zero: assert property (p_lead_zero)
        else $error("low bit before start was taken");

    property p_start;
        s_start |=> state_q == ST_MODE;
    endproperty
    a_start: assert property (p_start)
        else $error("start bit not recognised");

    property p_cmd_shift;
        cs_low && state_q == ST_CHAN && sclk_rise
            |=> cmd_q.channel_bit_0 == $past(cmd_in);
    endproperty
    a_cmd_shift: assert property (p_cmd_shift)
        else $error("channel bit not shifted in");

    property p_sample_open;
        cs_low && state_q == ST_CHAN && cnt_q == `SAC_CHAN_LAST && sclk_rise
            |=> mux_out.sample && state_q == ST_SAMPLE;
    endproperty
    a_sample_open: assert property (p_sample_open)
        else $error("hold switch did not close on last channel bit");

    property p_sample_close;
        s_hold_end |=> !mux_out.sample && !dout_out && !dout_oe_n_out
                       && sar_busy_q;
    endproperty
    a_sample_close: assert property (p_sample_close)
        else $error("hold did not end with null bit");

    // Counter instead of a long repetition: ten trials, never more
    property p_sar_ten;
        (sar_busy_q |-> sar_len_q < `SAC_SAR_STEPS)
        and ($fell(sar_busy_q) && $past(cs_low)
             |-> sar_len_q == `SAC_SAR_STEPS);
    endproperty
    a_sar_ten: assert property (p_sar_ten)
        else $error("approximation did not take ten steps");

    property p_dout_fall;
        dout_out != $past(dout_out) |-> $past(sclk_fall || !cs_low);
    endproperty
    a_dout_fall: assert property (p_dout_fall)
        else $error("output changed off a falling edge");

    property p_lsb_turn;
        cs_low && state_q == ST_MSB && cnt_q == `SAC_MSB_LAST && sclk_fall
            |=> state_q == ST_LSB && dout_out == $past(res_q[0]);
    endproperty
    a_lsb_turn: assert property (p_lsb_turn)
        else $error("no turn to reversed order after lowest bit");

    property p_zeros;
        cs_low && state_q == ST_ZEROS && sclk_fall |=> !dout_out;
    endproperty
    a_zeros: assert property (p_zeros)
        else $error("non-zero after reversed result");

    property p_pair;
        mux_out.sample && mux_out.diff
            |-> mux_out.pos[2:1] == mux_out.neg[2:1]
                && mux_out.pos[0] == cmd_q.channel_bit_0
                && mux_out.neg[0] != cmd_q.channel_bit_0;
    endproperty
    a_pair: assert property (p_pair)
        else $error("pair polarity wrong");

    property p_quiet_cmd;
        state_q inside {ST_STANDBY, ST_IDLE, ST_MODE, ST_CHAN, ST_SAMPLE}
            |-> dout_oe_n_out;
    endproperty
    a_quiet_cmd: assert property (p_quiet_cmd)
        else $error("output driven before command complete");

endmodule // sac_ctrl
`default_nettype wire

// [sac_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module sac_host_model (
    // Clock
    input  wire logic              clk_in,
    // Serial port of the host
    output logic                   select_standby_n_out,
    output logic                   sclk_out,
    output logic                   cmd_out,
    // Analog inputs and hold capacitor
    input  wire sac_pkg::sac_mux_t mux_in,
    input  wire logic [9:0]        trial_in,
    input  wire logic [7:0][10:0]  level_in,
    output logic                   comparator_out
);
    import sac_pkg::*;
    logic [10:0] held_q = 11'h000;
    // Idle host: select high, serial clock parked low
    initial begin
        select_standby_n_out = 1'b1;
        sclk_out = 1'b0;
        cmd_out = 1'b0;
    end
    // Capacitor follows the mux only while the switch is closed
    always @(posedge clk_in) begin
        if (mux_in.sample) begin
            held_q <= !mux_in.diff ? level_in[mux_in.pos]
                : (level_in[mux_in.pos] > level_in[mux_in.neg])
                ? level_in[mux_in.pos] - level_in[mux_in.neg]
                : 11'h000;
        end
    end
    // Levels past full scale pass every trial code
    assign comparator_out = held_q >= {1'b0, trial_in};
    // One session: leading zeros, start, config, then free clocks
    task automatic frame(input logic [3:0] cfg, input int lead,
                         input int extra, input logic [31:0] junk);
        logic [4:0] word;
        word = {1'b1, cfg};
        @(posedge clk_in) #1 select_standby_n_out = 1'b0;
        repeat (3) @(posedge clk_in);
        for (int i = 0; i < lead + 5 + extra; i++) begin
            // Fresh config every session
            #1 cmd_out = i < lead ? 1'b0
                : i < lead + 5 ? word[lead + 4 - i] : junk[i % 32];
            repeat (7) @(posedge clk_in);
            // 16 clk period, far above the minimum rate
            #1 sclk_out = 1'b1;
            repeat (8) @(posedge clk_in);
            #1 sclk_out = 1'b0;
            @(posedge clk_in);
        end
        #1 select_standby_n_out = 1'b1;
    endtask
endmodule // sac_host_model
`default_nettype wire

// [sac_ctrl_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module sac_ctrl_bench;
    import sac_pkg::*;
    typedef struct {
        int         lead;
        logic [9:0] res;
        sac_mux_t   mux;
    } sac_note_t;
    logic             clk_in = 1'b0;
    logic             rst_n_in = 1'b0;
    logic             sel_n, sclk, cmd, dout, oe_n, comp, standby, slow;
    sac_mux_t         mux;
    logic [9:0]       trial;
    logic [7:0][10:0] level = '0;
    logic [9:0]       got_w = 10'h000;
    sac_note_t        notes[$];
    int               errors = 0, check_count = 0, seed = 3;
    int               rise_n = 0, idx;

    always #10 clk_in = ~clk_in;

    sac_ctrl i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .select_standby_n_in(sel_n), .sclk_in(sclk), .cmd_in(cmd),
        .dout_out(dout), .dout_oe_n_out(oe_n), .mux_out(mux),
        .sar_trial_out(trial), .comparator_in(comp),
        .standby_out(standby), .slow_clock_out(slow));
    sac_host_model i_host (.clk_in(clk_in), .select_standby_n_out(sel_n),
        .sclk_out(sclk), .cmd_out(cmd), .mux_in(mux), .trial_in(trial),
        .level_in(level), .comparator_out(comp));

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic check_bit(input logic got, input logic exp,
                             input string what);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t %s got %b want %b", $time, what, got, exp);
        end
    endtask
    task automatic check_word(input logic [9:0] got, input logic [9:0] exp,
                              input string what);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask
    // Stream after null: MSB first, LSB first from bit 1, then zeros
    function automatic logic exp_bit(input int i, input logic [9:0] r);
        if (i >= 1 && i <= 10) return r[10 - i];
        if (i >= 11 && i <= 19) return r[i - 10];
        return 1'b0;
    endfunction

    // Monitor: host captures on the rising serial edge
    always @(negedge sel_n) rise_n = 0;
    always @(posedge sel_n) if (notes.size() > 0) void'(notes.pop_front());
    always @(posedge sclk) begin
        if (!sel_n && notes.size() > 0) begin
            rise_n++;
            idx = rise_n - notes[0].lead - 7;
            if (idx == -1) begin
                check_word({3'b000, mux},
                           {3'b000, notes[0].mux}, "mux");
                check_bit(oe_n, 1'b1, "oe before null");
                check_bit(standby, 1'b0, "active");
            end
            if (idx == 1) begin
                check_bit(mux.sample, 1'b0, "hold open");
                check_word(trial, notes[0].res, "trial");
            end
            if (idx >= 0) begin
                check_bit(oe_n, 1'b0, "oe driving");
                check_bit(dout, exp_bit(idx, notes[0].res), "dout");
                if (idx >= 1 && idx <= 10) got_w = {got_w[8:0], dout};
                if (idx == 10) begin
                    check_word(got_w, notes[0].res, "msb");
                end
            end
        end
    end

    // Driver: note the expected frame, then let the host run it
    task automatic run(input logic [3:0] cfg, input int extra,
                       input bit rnd);
        sac_note_t n;
        logic [2:0] p, q;
        logic [10:0] v;
        if (rnd) foreach (level[i]) level[i] = 11'({$random(seed)} % 1024);
        p = cfg[2:0];
        q = cfg[3] ? cfg[2:0] : {cfg[2:1], ~cfg[0]};
        v = cfg[3] ? level[p] : level[p] > level[q] ? level[p] - level[q] : 0;
        n.lead = {$random(seed)} % 8;
        n.res = v > 11'd1023 ? 10'h3FF : v[9:0];
        n.mux = {1'b1, ~cfg[3], p, q};
        notes.push_back(n);
        i_host.frame(cfg, n.lead, extra, $random(seed));
        repeat (2) @(posedge clk_in);
        check_bit(standby, 1'b1, "standby");
        check_bit(oe_n, 1'b1, "released");
        check_bit(mux.sample, 1'b0, "hold off");
    endtask

    initial begin
        repeat (10) @(posedge clk_in);
        #1 rst_n_in = 1'b1;
        repeat (3) @(posedge clk_in);
        check_bit(standby, 1'b1, "reset standby");
        for (int c = 0; c < 16; c++) run(4'(c), 30, 1'b1);
        run(4'h9, 5, 1'b1);
        level[6] = 11'd300;
        level[7] = 11'd300;
        run(4'h7, 12, 1'b0);
        level[4] = 11'd1050;
        level[5] = 11'd5;
        run(4'h4, 12, 1'b0);
        check_bit(slow, 1'b0, "slow clock");
        // Abort while the hold switch is still closed
        run(4'h2, 0, 1'b1);
        // Reset between runs; select is seen high before the next session
        #1 rst_n_in = 1'b0;
        repeat (2) @(posedge clk_in);
        #1 rst_n_in = 1'b1;
        run(4'hD, 30, 1'b1);
        tally_and_finish();
    end

    // Watchdog: about five times the expected run
    initial begin
        repeat (60000) @(posedge clk_in);
        errors++;
        $display("[ERR] %0t watchdog expired", $time);
        tally_and_finish();
    end
endmodule // sac_ctrl_bench
`default_nettype wire
